/* File: src/accumulator_logic_unit.sv */
// How it works
// - Store-high-byte writes accumulator bits 15:8 into the word's upper byte, lower byte kept.
// - Single-word AND merges the low 16 accumulator bits with the memory word.
// - After single-word AND the zero flag is set exactly when the accumulator is zero.
// - Double AND and_with_stack_op all 32 bits with a word pair or a 32-bit constant.
// - After double AND the zero and negative flags follow the result.
// - Bit-range AND and_with_stack_op the accumulator with the lowest 1 to 32 discrete bits, chosen by a count.
// - After bit-range AND the zero and negative flags follow the result.
// - AND-with-stack and_with_stack_op the accumulator with the top stack entry.
// - AND-with-stack pops the top entry and moves every other entry up one level.
// - After AND-with-stack the zero and negative flags follow the result.
// - Single-word OR merges the low 16 accumulator bits with the memory word.
// - After single-word OR the zero flag is set exactly when the accumulator is zero.
// - Double OR ors all 32 bits with a word pair or constant and sets zero and negative flags.
// - A flag holds only until the next operation that writes the same flag.
module accumulator_logic_unit
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic op_valid,
  input wire alu_pkg::op_e op_code,
  input wire logic [alu_pkg::WORD_W-1:0] mem_word_lo,
  input wire logic [alu_pkg::WORD_W-1:0] mem_word_hi,
  input wire logic [alu_pkg::ACC_W-1:0] const_value,
  input wire logic use_const,
  input wire logic [alu_pkg::ACC_W-1:0] discrete_bits,
  input wire logic [alu_pkg::CNT_W-1:0] bit_count,
  output logic [alu_pkg::ACC_W-1:0] accumulator,
  output logic [alu_pkg::ACC_W-1:0] stack_top,
  output logic zero_flag,
  output logic negative_flag,
  output logic mem_write,
  output logic [alu_pkg::WORD_W-1:0] mem_write_data,
  output logic op_done
);
  import alu_pkg::*;

  // ==========================================================
  // Operand shaping
  logic [ACC_W-1:0] stack [STACK_DEPTH];
  logic [ACC_W-1:0] pair_operand;
  logic [ACC_W-1:0] range_mask;
  logic [ACC_W-1:0] range_operand;
  logic [ACC_W-1:0] next_acc;
  logic writes_acc;
  logic writes_neg;

  // Word pair or constant for the double forms
  assign pair_operand = use_const ? const_value : {mem_word_hi, mem_word_lo};

  // Count outside 1..32 is clamped so an illegal operand cannot blow up the mask
  always_comb
  begin
    range_mask = '0;
    for (int i = 0; i < ACC_W; i++)
    begin
      if (i < int'(bit_count) || int'(bit_count) > BIT_COUNT_MAX)
        range_mask[i] = 1'b1;
    end
    if (int'(bit_count) < BIT_COUNT_MIN)
      range_mask = {{(ACC_W-1){1'b0}}, 1'b1};
  end

  // Bits above the run read as zero, so the AND clears them
  assign range_operand = discrete_bits & range_mask;

  // ==========================================================
  // Result selection
  always_comb
  begin
    next_acc = accumulator;
    writes_acc = 1'b0;
    writes_neg = 1'b0;
    if (op_valid)
    begin
      case (op_code)
        and_word_op:
        begin
          // Low-word forms yield a 16-bit result in the accumulator
          next_acc = {{(ACC_W-WORD_W){1'b0}}, accumulator[WORD_W-1:0] & mem_word_lo};
          writes_acc = 1'b1;
        end
        or_word_op:
        begin
          next_acc = {{(ACC_W-WORD_W){1'b0}}, accumulator[WORD_W-1:0] | mem_word_lo};
          writes_acc = 1'b1;
        end
        and_double_op:
        begin
          next_acc = accumulator & pair_operand;
          writes_acc = 1'b1;
          writes_neg = 1'b1;
        end
        or_double_op:
        begin
          next_acc = accumulator | pair_operand;
          writes_acc = 1'b1;
          writes_neg = 1'b1;
        end
        and_bit_range_op:
        begin
          next_acc = accumulator & range_operand;
          writes_acc = 1'b1;
          writes_neg = 1'b1;
        end
        and_with_stack_op:
        begin
          next_acc = accumulator & stack[0];
          writes_acc = 1'b1;
          writes_neg = 1'b1;
        end
        load_double_op:
        begin
          // Loading gives test code a way to seed the accumulator; flags untouched
          next_acc = pair_operand;
        end
        default:
        begin
          next_acc = accumulator;
        end
      endcase
    end
  end

  // ==========================================================
  // Accumulator
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      accumulator <= ACC_RESET;
    else if (op_valid && op_code != store_high_byte_op && op_code != push_op)
      accumulator <= next_acc;
  end

  // ==========================================================
  // Accumulator stack
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < STACK_DEPTH; i++)
        stack[i] <= ACC_RESET;
    end
    else if (op_valid && op_code == and_with_stack_op)
    begin
      // Pop: entries move up, bottom refills with zero
      for (int i = 0; i < STACK_DEPTH - 1; i++)
        stack[i] <= stack[i+1];
      stack[STACK_DEPTH-1] <= ACC_RESET;
    end
    else if (op_valid && op_code == push_op)
    begin
      for (int i = 1; i < STACK_DEPTH; i++)
        stack[i] <= stack[i-1];
      stack[0] <= accumulator;
    end
  end

  // Registered copy of the top level for observation
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      stack_top <= ACC_RESET;
    else if (op_valid && op_code == and_with_stack_op)
      stack_top <= stack[1];
    else if (op_valid && op_code == push_op)
      stack_top <= accumulator;
  end

  // ==========================================================
  // Status flags
  // Each flag is only rewritten by an operation that owns it, so it holds till then
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      zero_flag <= 1'b0;
    else if (writes_acc)
      zero_flag <= ~|next_acc;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      negative_flag <= 1'b0;
    else if (writes_neg)
      negative_flag <= next_acc[SIGN_BIT];
  end

  // ==========================================================
  // Store-high-byte path: merge keeps the memory word's low byte
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      mem_write <= 1'b0;
      mem_write_data <= MEM_RESET;
    end
    else
    begin
      mem_write <= op_valid && op_code == store_high_byte_op;
      if (op_valid && op_code == store_high_byte_op)
        mem_write_data <= {accumulator[WORD_W-1:HIGH_BYTE_LSB],
                           mem_word_lo[BYTE_W-1:0]};
    end
  end

  // One-cycle completion pulse for every accepted operation
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      op_done <= 1'b0;
    else
      op_done <= op_valid && op_code != op_none;
  end

  // ==========================================================
  // Checks
  // Store merges the high byte and leaves the accumulator alone
  store_merge_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    op_valid && op_code == store_high_byte_op |=> mem_write
    && mem_write_data == {$past(accumulator[15:8]), $past(mem_word_lo[7:0])}
    && $stable(accumulator)) else $error("store high byte wrong");

  // A write pulse without a store would corrupt the addressed word
  write_pulse_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mem_write |-> $past(op_valid) && $past(op_code) == store_high_byte_op)
    else $error("stray memory write");

  // Word forms: low 16 bits only, zero flag only
  and_word_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    op_valid && op_code == and_word_op |=>
    accumulator == {16'h0000, $past(accumulator[15:0]) & $past(mem_word_lo)}
    && zero_flag == (accumulator == 32'h00000000)) else $error("word and wrong");

  or_word_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    op_valid && op_code == or_word_op |=>
    accumulator == {16'h0000, $past(accumulator[15:0]) | $past(mem_word_lo)}
    && zero_flag == (accumulator == 32'h00000000)) else $error("word or wrong");

  // Double forms, both operand sources
  double_and_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    op_valid && op_code == and_double_op && use_const |=>
    accumulator == ($past(accumulator) & $past(const_value))
    && negative_flag == accumulator[31]) else $error("double and wrong");

  pair_and_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    op_valid && op_code == and_double_op && !use_const |=>
    accumulator == ($past(accumulator) & {$past(mem_word_hi), $past(mem_word_lo)}))
    else $error("pair and wrong");

  double_or_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    op_valid && op_code == or_double_op && !use_const |=>
    accumulator == ($past(accumulator) | {$past(mem_word_hi), $past(mem_word_lo)})
    && zero_flag == (accumulator == 32'h00000000)) else $error("double or wrong");

  const_or_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    op_valid && op_code == or_double_op && use_const |=>
    accumulator == ($past(accumulator) | $past(const_value))) else $error("const or wrong");

  // Bit range: a short run and the full width
  bit_range_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    op_valid && op_code == and_bit_range_op && bit_count == 6'h04 |=>
    accumulator == ($past(accumulator) & {28'h0000000, $past(discrete_bits[3:0])})
    && negative_flag == 1'b0) else $error("bit range and wrong");

  range_full_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    op_valid && op_code == and_bit_range_op && bit_count == 6'h20 |=>
    accumulator == ($past(accumulator) & $past(discrete_bits))) else $error("full range wrong");

  // Stack: operand, pop and refill of the bottom level
  stack_pop_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    op_valid && op_code == and_with_stack_op |=>
    accumulator == ($past(accumulator) & $past(stack[0]))
    && stack[0] == $past(stack[1]) && stack_top == stack[0]
    && negative_flag == accumulator[31]) else $error("stack and wrong");

  stack_fill_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    op_valid && op_code == and_with_stack_op |=>
    stack[STACK_DEPTH-1] == ACC_RESET && stack[STACK_DEPTH-2] == $past(stack[STACK_DEPTH-1]))
    else $error("stack refill wrong");

  // Flag ownership: a flag moves only under an operation that writes it
  flag_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    op_valid && (op_code == and_word_op || op_code == or_word_op) |=>
    $stable(negative_flag)) else $error("negative flag disturbed");

  flag_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    op_valid && (op_code == load_double_op || op_code == store_high_byte_op)
    |=> $stable(zero_flag) && $stable(negative_flag)) else $error("flags disturbed");

  zero_nor_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    op_valid && (op_code == and_word_op || op_code == or_word_op
    || op_code == and_double_op || op_code == or_double_op
    || op_code == and_bit_range_op || op_code == and_with_stack_op)
    |=> zero_flag == (accumulator == '0)) else $error("zero flag wrong");

  sign_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    op_valid && (op_code == and_double_op || op_code == or_double_op
    || op_code == and_bit_range_op || op_code == and_with_stack_op)
    |=> negative_flag == accumulator[SIGN_BIT]) else $error("negative flag wrong");

  cover_stack_zero: cover property (@(posedge clk_sys) disable iff (!rst_n)
    op_valid && op_code == and_with_stack_op ##1 zero_flag);
  cover_neg_or: cover property (@(posedge clk_sys) disable iff (!rst_n)
    op_valid && op_code == or_double_op ##1 negative_flag);
  cover_store: cover property (@(posedge clk_sys) disable iff (!rst_n) mem_write);
  cover_range_full: cover property (@(posedge clk_sys) disable iff (!rst_n)
    op_valid && op_code == and_bit_range_op && bit_count == 6'h20 ##1 negative_flag);

endmodule

/* File: src/alu_pkg.sv */
package alu_pkg;

  // ==========================================================
  // Widths
  localparam int ACC_W = 32;
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam int STACK_DEPTH = 8;
  localparam int CNT_W = 6;
  localparam int HIGH_BYTE_LSB = 8;
  localparam int SIGN_BIT = 31;
  localparam int BIT_COUNT_MIN = 1;
  localparam int BIT_COUNT_MAX = 32;

  // ==========================================================
  // Reset values
  localparam logic [31:0] ACC_RESET = 32'h00000000;
  localparam logic [15:0] MEM_RESET = 16'h0000;

  // ==========================================================
  // Operation codes
  typedef enum logic [3:0]
  {
    op_none,
    store_high_byte_op,
    and_word_op,
    and_double_op,
    and_bit_range_op,
    and_with_stack_op,
    or_word_op,
    or_double_op,
    load_double_op,
    push_op
  } op_e;

endpackage

/* File: test/accumulator_logic_unit_tb.sv */
module accumulator_logic_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import alu_pkg::*;
  // ==========================================================
  // Stimulus and observed signals
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic op_valid = 1'b0;
  op_e op_code = op_none;
  logic use_const = 1'b1;
  logic [31:0] const_value = 32'h0;
  logic [31:0] discrete_bits = 32'h0;
  logic [5:0] bit_count = 6'h00;
  logic [31:0] accumulator;
  logic [31:0] stack_top;
  logic zero_flag;
  logic negative_flag;
  logic mem_write;
  logic op_done;
  logic [15:0] mem_write_data;
  logic [15:0] word_lo;
  logic [15:0] word_hi;
  logic mem_seed = 1'b1;
  logic [15:0] seed_lo = 16'h0000;
  logic [15:0] seed_hi = 16'h0000;
  int fail_count = 0;
  int checks_done = 0;
  // Free-running 200 MHz clock
  always #2.5 clk_sys = ~clk_sys;
  accumulator_logic_unit uut
  (
    .clk_sys(clk_sys), .rst_n(rst_n), .op_valid(op_valid), .op_code(op_code),
    .mem_word_lo(word_lo), .mem_word_hi(word_hi), .const_value(const_value),
    .use_const(use_const), .discrete_bits(discrete_bits), .bit_count(bit_count),
    .accumulator(accumulator), .stack_top(stack_top), .zero_flag(zero_flag),
    .negative_flag(negative_flag), .mem_write(mem_write),
    .mem_write_data(mem_write_data), .op_done(op_done)
  );
  mem_model mem
  (
    .clk_sys(clk_sys), .seed(mem_seed), .seed_lo(seed_lo), .seed_hi(seed_hi),
    .mem_write(mem_write), .mem_write_data(mem_write_data),
    .word_lo(word_lo), .word_hi(word_hi)
  );
  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One operation; outputs are checked 1 ns after the taking edge
  task automatic run(input op_e c, input logic [31:0] v, input logic [5:0] n);
    @(posedge clk_sys);
    #1;
    op_valid = 1'b1;
    op_code = c;
    const_value = v;
    discrete_bits = v;
    bit_count = n;
    @(posedge clk_sys);
    #1;
    op_valid = 1'b0;
    chk({31'h0, op_done}, 32'h1);
  endtask
  task automatic ld(input logic [31:0] v);
    use_const = 1'b1;
    run(load_double_op, v, 6'h00);
  endtask
  // Seed the memory word pair for one cycle through the model's port
  task automatic mem_set(input logic [15:0] hi, input logic [15:0] lo);
    @(posedge clk_sys);
    #1;
    mem_seed = 1'b1;
    seed_hi = hi;
    seed_lo = lo;
    @(posedge clk_sys);
    #1;
    mem_seed = 1'b0;
  endtask
  task automatic res(input logic [31:0] a, input logic z, input logic n);
    chk(accumulator, a);
    chk({30'h0, zero_flag, negative_flag}, {30'h0, z, n});
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_store();
    ld(32'h0000A5C3);
    mem_set(16'h0000, 16'h1234);
    run(store_high_byte_op, 32'h0, 6'h00);
    chk({15'h0, mem_write, mem_write_data}, 32'h1A534);
    chk(accumulator, 32'h0000A5C3);
    @(posedge clk_sys);
    #1;
    chk({16'h0, word_lo}, 32'h0000A534);
    $display("test store done");
  endtask
  task automatic t_and();
    ld(32'hFFFFFFFF);
    run(and_double_op, 32'h8000FFF0, 6'h00);
    res(32'h8000FFF0, 1'b0, 1'b1);
    mem_set(16'h0000, 16'h000F);
    run(and_word_op, 32'h0, 6'h00);
    res(32'h0, 1'b1, 1'b1);
    ld(32'hFFFFFFFF);
    use_const = 1'b0;
    mem_set(16'h1234, 16'h5678);
    run(and_double_op, 32'h0, 6'h00);
    res(32'h12345678, 1'b0, 1'b0);
    $display("test and done");
  endtask
  task automatic t_range();
    ld(32'hFFFFFFFF);
    run(and_bit_range_op, 32'hFFFFFFFF, 6'h04);
    res(32'h0000000F, 1'b0, 1'b0);
    run(and_bit_range_op, 32'hFFFFFFFE, 6'h01);
    res(32'h0, 1'b1, 1'b0);
    ld(32'hFFFFFFFF);
    run(and_bit_range_op, 32'h80000001, 6'h20);
    res(32'h80000001, 1'b0, 1'b1);
    ld(32'hFFFFFFFF);
    run(and_bit_range_op, 32'h0000FFFF, 6'h00);
    res(32'h00000001, 1'b0, 1'b0);
    ld(32'hFFFFFFFF);
    run(and_bit_range_op, 32'h8000FFFF, 6'h3F);
    res(32'h8000FFFF, 1'b0, 1'b1);
    $display("test range done");
  endtask
  task automatic t_stack();
    ld(32'h92345678);
    run(push_op, 32'h0, 6'h00);
    chk(stack_top, 32'h92345678);
    ld(32'h8F0F0F0F);
    run(push_op, 32'h0, 6'h00);
    chk(stack_top, 32'h8F0F0F0F);
    ld(32'hFF00FF00);
    run(and_with_stack_op, 32'h0, 6'h00);
    res(32'h8F000F00, 1'b0, 1'b1);
    chk(stack_top, 32'h92345678);
    run(and_with_stack_op, 32'h0, 6'h00);
    res(32'h82000600, 1'b0, 1'b1);
    chk(stack_top, 32'h0);
    run(and_with_stack_op, 32'h0, 6'h00);
    res(32'h0, 1'b1, 1'b0);
    $display("test stack done");
  endtask
  task automatic t_or();
    ld(32'hFFFF0001);
    mem_set(16'h0000, 16'h8000);
    run(or_word_op, 32'h0, 6'h00);
    res(32'h00008001, 1'b0, 1'b0);
    use_const = 1'b0;
    mem_set(16'h8000, 16'h0000);
    run(or_double_op, 32'h0, 6'h00);
    res(32'h80008001, 1'b0, 1'b1);
    ld(32'h0);
    run(or_double_op, 32'h0, 6'h00);
    res(32'h0, 1'b1, 1'b0);
    $display("test or done");
  endtask
  // ==========================================================
  // Verdict, reached from the main sequence or the watchdog
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Watchdog well beyond the 75 or so cycles the tests need
  initial
  begin
    #20000;
    fail_count++;
    summarize();
  end
  initial
  begin
    repeat (6) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    mem_seed = 1'b0;
    res(32'h0, 1'b0, 1'b0);
    t_store();
    t_and();
    t_range();
    t_stack();
    t_or();
    summarize();
  end
endmodule

/* File: test/mem_model.sv */
// ==========================================================
// Data memory word pair seen by the logic unit
module mem_model
(
  input wire logic clk_sys,
  input wire logic seed,
  input wire logic [15:0] seed_lo,
  input wire logic [15:0] seed_hi,
  input wire logic mem_write,
  input wire logic [15:0] mem_write_data,
  output logic [15:0] word_lo,
  output logic [15:0] word_hi
);
  timeunit 1ns;
  timeprecision 1ps;
  // One process owns both words; the bench seeds them through the seed port
  always @(posedge clk_sys)
  begin
    if (seed)
    begin
      word_lo <= seed_lo;
      word_hi <= seed_hi;
    end
    else if (mem_write)
      word_lo <= mem_write_data;
  end
endmodule
